// ### hdl/wrx_defs.vh
// Notes on behaviour
// - Interrupt pin open-drain, active low.
// - Interrupt on shutdown, 140C, thermistor, OC, OV.
// - Latch which fault caused the interrupt.
// - Shutdown input high disables the receiver.
// - Die above 140C shuts receiver down.
// - Above 130C set flag, send stop packet.
// - Thermistor below 0.6V triggers overtemperature.
// - Charge-complete high sends stop-transfer packet.
// - Report gain times power plus offset.
// - 0.9V trims unity; grounded trims disable adjust.
// - Periodically send received-power packet.
// - Report measured power plus accuracy margin.
// - Trim from serial interface or OTP.
// - Signal by switching coil capacitors at 2Kbps.
// - Differential bi-phase coding at 2kHz.
// - One is two transitions, zero one.
// - Byte is start, 8 data, parity, stop.
// - Packet is preamble, header, message, checksum.
// - Run protocol only above undervoltage lockout.
// - Resend stop packets until supply drops; code latches only charge-complete stops, others end with their condition.
// - Above 12V send control error packets.
`ifndef WRX_DEFS_VH
`define WRX_DEFS_VH
`define WRX_CLK_HZ         50000000
`define WRX_HALF_BIT_HZ    4000
`define WRX_HALF_BIT_CYC   (`WRX_CLK_HZ / `WRX_HALF_BIT_HZ)
`define WRX_ADC_UNITY      12'h6DB
`define WRX_ADC_FULL       12'hFFF
`define WRX_PWR_MARGIN_MW  16'h015E
`define WRX_PREAMBLE_BITS  11
`define WRX_HDR_RPP        8'h04
`define WRX_HDR_EPT        8'h02
`define WRX_HDR_CEP        8'h03
`define WRX_EPT_OVERTEMP   8'h03
`define WRX_EPT_CHARGED    8'h01
`define WRX_EPT_FAULT      8'h02
`define WRX_CEP_LOWER      8'hF6
`define WRX_RPP_PERIOD_CYC 25000000
`define WRX_FLT_OC         0
`define WRX_FLT_OV         1
`define WRX_FLT_TEMP       2
`define WRX_FLT_SHDN       3
`endif

// ### hdl/wrx_fifo.v
`timescale 1ns/1ps
module wrx_fifo #(
	parameter W  = 8,
	parameter D  = 16,
	parameter AW = 4
) (
	input  wire         clock_i,
	input  wire         sys_rst_i,
	// Fill side.
	input  wire         in_valid_i,
	output wire         in_ready_o,
	input  wire [W-1:0] in_data_i,
	// Drain side.
	output wire         out_valid_o,
	input  wire         out_ready_i,
	output wire [W-1:0] out_data_o
);
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0]   cnt_q;
	wire push = in_valid_i & in_ready_o;
	wire pop  = out_valid_o & out_ready_i;
	localparam [AW:0] FULL_CNT = D;
	assign in_ready_o  = (cnt_q != FULL_CNT);
	assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
	assign out_data_o  = mem[rd_q];
	always @(posedge clock_i) begin
		if (push)
			mem[wr_q] <= in_data_i;
	end
	always @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			if (push & ~pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop & ~push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule // wrx_fifo

// ### hdl/wrx_top.v
`timescale 1ns/1ps
`include "wrx_defs.vh"
module wrx_top #(
	parameter RPP_PERIOD = `WRX_RPP_PERIOD_CYC,
	parameter HALF_BIT   = `WRX_HALF_BIT_CYC
) (
	input  wire        clock_i,
	input  wire        sys_rst_i,
	// Pins from outside, synchronised here.
	input  wire        shdn_n_i,
	input  wire        charge_done_i,
	input  wire        uvlo_ok_i,
	// Comparator levels from the analog side.
	input  wire        die_over130_i,
	input  wire        die_over140_i,
	input  wire        ext_temp_low_i,
	input  wire        over_current_i,
	input  wire        over_voltage_i,
	input  wire        rect_over12_i,
	// Power and trim conversions.
	input  wire [15:0] meas_power_mw_i,
	input  wire [11:0] power_gain_trim_i,
	input  wire [11:0] power_offset_trim_i,
	input  wire        trim_sel_otp_i,
	input  wire [11:0] otp_gain_i,
	input  wire [11:0] otp_offset_i,
	input  wire        status_clr_i,
	// Fault and status.
	output wire        fault_int_n_o,
	output wire        fault_int_oe_o,
	output reg  [3:0]  fault_cause_o,
	output reg         overtemp_flag_o,
	output wire        rx_enable_o,
	output reg  [15:0] received_power_report_o,
	// Load modulation of coil_node_a and coil_node_b.
	output reg         mod_sw_o
);
	// Two-flop synchronisers for all asynchronous levels.
	reg [9:0] s1_q, s2_q;
	always @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s1_q <= 10'h001;
			s2_q <= 10'h001;
		end else begin
			s1_q <= {rect_over12_i, over_voltage_i, over_current_i,
				ext_temp_low_i, die_over140_i, die_over130_i,
				uvlo_ok_i, charge_done_i, 1'b0, shdn_n_i};
			s2_q <= s1_q;
		end
	end
	wire shdn   = s2_q[0];
	wire chg    = s2_q[2];
	wire uv_ok  = s2_q[3];
	wire t130   = s2_q[4];
	wire t140   = s2_q[5];
	wire ts_low = s2_q[6];
	wire oc     = s2_q[7];
	wire ov     = s2_q[8];
	wire v12    = s2_q[9];

	wire hot = t140 | ts_low;
	wire [3:0] flt = {shdn, hot, ov, oc};
	assign fault_int_oe_o = |flt;
	assign fault_int_n_o  = 1'b0;
	assign rx_enable_o = ~shdn & ~t140 & uv_ok;

	always @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			fault_cause_o   <= 4'h0;
			overtemp_flag_o <= 1'b0;
		end else begin
			fault_cause_o <= flt | (status_clr_i ? 4'h0 : fault_cause_o);
			overtemp_flag_o <= t130 | ts_low |
				(status_clr_i ? 1'b0 : overtemp_flag_o);
		end
	end

	wire [11:0] g = trim_sel_otp_i ? otp_gain_i : power_gain_trim_i;
	wire [11:0] o = trim_sel_otp_i ? otp_offset_i : power_offset_trim_i;
	wire bypass = (g == 12'h000) && (o == 12'h000);
	wire [27:0] prod = meas_power_mw_i * g;
	wire [27:0] scl  = prod / 28'd1755;
	wire signed [18:0] adj = $signed({1'b0, scl[17:0]}) +
		$signed({7'h00, o}) - 19'sd1755;
	wire [17:0] base = bypass ? {2'b00, meas_power_mw_i} :
		(adj[18] ? 18'h00000 : adj[17:0]);
	wire [17:0] rep = base + {2'b00, `WRX_PWR_MARGIN_MW};
	always @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			received_power_report_o <= 16'h0000;
		else
			received_power_report_o <= (|rep[17:16]) ? 16'hFFFF :
				rep[15:0];
	end

	// Packet scheduler feeding bytes to the FIFO.
	localparam P_IDLE = 2'h0;
	localparam P_HDR  = 2'h1;
	localparam P_MSG  = 2'h2;
	localparam P_SUM  = 2'h3;
	reg [1:0]  ps_q;
	reg [7:0]  hdr_q, msg_q, sum_q;
	reg [31:0] tick_q;
	reg        stop_q;
	wire       f_rdy;
	reg        f_vld;
	reg [7:0]  f_dat;
	wire       ent_vld;
	wire [7:0] ent_dat;
	reg        ent_rdy;
	wire req_stop = chg | t130 | ts_low | oc | ov | stop_q;
	always @* begin
		f_vld = (ps_q != P_IDLE);
		case (ps_q)
		P_HDR:   f_dat = hdr_q;
		P_MSG:   f_dat = msg_q;
		P_SUM:   f_dat = sum_q;
		default: f_dat = 8'h00;
		endcase
	end
	always @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ps_q   <= P_IDLE;
			hdr_q  <= 8'h00;
			msg_q  <= 8'h00;
			sum_q  <= 8'h00;
			tick_q <= 32'h0;
			stop_q <= 1'b0;
		end else if ((!uv_ok || shdn) && ps_q == P_IDLE) begin
			// stop ends with the supply
			// A packet already begun is finished so no partial packet is left queued.
			ps_q   <= P_IDLE;
			stop_q <= 1'b0;
			tick_q <= 32'h0;
		end else begin
			if (chg)
				stop_q <= 1'b1;
			if (tick_q != 32'h0)
				tick_q <= tick_q - 1'b1;
			case (ps_q)
			P_IDLE: begin
				if (tick_q == 32'h0) begin
					tick_q <= RPP_PERIOD;
					ps_q   <= P_HDR;
					if (req_stop) begin
						hdr_q <= `WRX_HDR_EPT;
						msg_q <= chg | stop_q ? `WRX_EPT_CHARGED :
							(t130 | ts_low) ? `WRX_EPT_OVERTEMP :
							`WRX_EPT_FAULT;
					end else if (v12) begin
						hdr_q <= `WRX_HDR_CEP;
						msg_q <= `WRX_CEP_LOWER;
					end else begin
						hdr_q <= `WRX_HDR_RPP;
						msg_q <= received_power_report_o[15:8];
					end
				end
			end
			P_HDR: if (f_rdy) begin
				ps_q <= P_MSG;
			end
			P_MSG: if (f_rdy) begin
				sum_q <= hdr_q ^ msg_q;
				ps_q  <= P_SUM;
			end
			P_SUM: if (f_rdy) begin
				ps_q <= P_IDLE;
			end
			default: ps_q <= P_IDLE;
			endcase
		end
	end

	wrx_fifo #(.W(8), .D(16), .AW(4)) u_fifo (
		.clock_i     (clock_i),
		.sys_rst_i   (sys_rst_i),
		.in_valid_i  (f_vld),
		.in_ready_o  (f_rdy),
		.in_data_i   (f_dat),
		.out_valid_o (ent_vld),
		.out_ready_i (ent_rdy),
		.out_data_o  (ent_dat)
	);

	// Bit serialiser: preamble, then framed bytes.
	reg [31:0] hb_q;
	reg        half_q;
	reg        busy_q;
	reg [3:0]  pre_q;
	reg [10:0] sh_q;
	reg [3:0]  nb_q;
	// Byte index within a packet: header, message, checksum.
	reg [1:0]  bix_q;
	localparam [3:0] PRE_N = `WRX_PREAMBLE_BITS;
	wire hb_tick = (hb_q == 32'h0);
	wire cur_bit = (pre_q != 4'h0) ? 1'b1 : sh_q[0];
	always @* begin
		ent_rdy = ~busy_q & rx_enable_o;
	end
	always @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			hb_q   <= 32'h0;
			half_q <= 1'b0;
			busy_q <= 1'b0;
			pre_q  <= 4'h0;
			sh_q   <= 11'h7FF;
			nb_q   <= 4'h0;
			bix_q  <= 2'd0;
			mod_sw_o <= 1'b0;
		end else if (ent_vld & ent_rdy) begin
			// start, LSB first, odd parity, stop
			sh_q   <= {1'b1, ~^ent_dat, ent_dat, 1'b0};
			nb_q   <= 4'd11;
			busy_q <= 1'b1;
			pre_q  <= (bix_q == 2'd0) ? PRE_N : 4'h0;
			bix_q  <= (bix_q == 2'd2) ? 2'd0 : bix_q + 2'd1;
			hb_q   <= 32'h0;
			half_q <= 1'b0;
		end else if (busy_q) begin
			hb_q <= hb_tick ? HALF_BIT - 1 : hb_q - 1'b1;
			if (hb_tick) begin
				if (nb_q == 4'h0 && pre_q == 4'h0) begin
					// The stop bit's second half lasts a full span too.
					busy_q <= 1'b0;
				end else begin
					if (!half_q)
						mod_sw_o <= ~mod_sw_o;
					else if (cur_bit)
						mod_sw_o <= ~mod_sw_o;
					half_q <= ~half_q;
					if (half_q) begin
						if (pre_q != 4'h0)
							pre_q <= pre_q - 1'b1;
						else begin
							sh_q <= {1'b1, sh_q[10:1]};
							nb_q <= nb_q - 1'b1;
						end
					end
				end
			end
		end
	end
endmodule // wrx_top

// ### sim/wrx_tx_model.sv
`timescale 1ns/1ps
// Transmitter demodulator: turns load modulation edges back into bits.
module wrx_tx_model #(
	parameter HALF_BIT = 4
) (
	input  logic clock_i,
	input  logic sys_rst_i,
	input  logic mod_sw_i,
	output logic bit_valid_o,
	output logic bit_o,
	output logic idle_o
);
	logic [7:0] gap_q;
	logic       prev_q;
	logic       half_q;
	assign idle_o = gap_q > 3 * HALF_BIT;
	always @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			gap_q <= 8'hFF;
			prev_q <= 1'h0;
			half_q <= 1'h0;
			bit_valid_o <= 1'h0;
			bit_o <= 1'h0;
		end else begin
			bit_valid_o <= 1'h0;
			prev_q <= mod_sw_i;
			// transmitter acts on decoded bits and on the idle gap (idle_o)
			if (mod_sw_i != prev_q) begin
				gap_q <= 8'h01;
				if (idle_o)
					half_q <= 1'h0;
				else if (gap_q > HALF_BIT + HALF_BIT / 2) begin
					bit_valid_o <= 1'h1;
					bit_o <= 1'h0;
					half_q <= 1'h0;
				end else begin
					bit_valid_o <= half_q;
					bit_o <= 1'h1;
					half_q <= ~half_q;
				end
			end else if (gap_q != 8'hFF) begin
				gap_q <= gap_q + 8'h01;
				// A trailing one ends with no following edge.
				if (half_q && gap_q == 2 * HALF_BIT) begin
					bit_valid_o <= 1'h1;
					bit_o <= 1'h1;
					half_q <= 1'h0;
				end
			end
		end
	end
endmodule // wrx_tx_model

// ### sim/wrx_asserts.sv
`timescale 1ns/1ps
module wrx_asserts #(
	parameter RPP_PERIOD = 2000,
	parameter HALF_BIT   = 4
) (
	input logic       clock_i,
	input logic       sys_rst_i,
	input logic       shdn_n_i,
	input logic       die_over130_i,
	input logic       die_over140_i,
	input logic       over_current_i,
	input logic       status_clr_i,
	input logic       fault_int_n_o,
	input logic       fault_int_oe_o,
	input logic [3:0] fault_cause_o,
	input logic       overtemp_flag_o,
	input logic       rx_enable_o,
	input logic       mod_sw_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (sys_rst_i);
	a_int_pin_low: assert property (!fault_int_n_o)
		else $error("interrupt level high");
	a_int_on_oc: assert property (
		$rose(over_current_i) |-> ##[1:3] fault_int_oe_o)
		else $error("no interrupt on over-current");
	a_cause_oc: assert property (over_current_i[*5] |-> fault_cause_o[0])
		else $error("cause not recorded");
	a_cause_hold: assert property (
		(!status_clr_i)[*3] ##0 fault_cause_o[3] |=> fault_cause_o[3])
		else $error("cause lost");
	a_shdn_off: assert property (shdn_n_i[*4] |-> !rx_enable_o)
		else $error("enabled in shutdown");
	a_hot_off: assert property (die_over140_i[*4] |-> !rx_enable_o)
		else $error("enabled when hot");
	a_flag_hot: assert property (die_over130_i[*5] |-> overtemp_flag_o)
		else $error("flag not set");
	a_bit_min: assert property (
		$changed(mod_sw_o) |=> $stable(mod_sw_o)[*3])
		else $error("edges too close");
endmodule // wrx_asserts
bind wrx_top wrx_asserts #(.RPP_PERIOD(RPP_PERIOD), .HALF_BIT(HALF_BIT))
	chk_u (.*);

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic        clock_i = 1'h0, sys_rst_i = 1'h1, shdn_n_i = 1'h0;
	logic        charge_done_i = 1'h0, uvlo_ok_i = 1'h1, die_over130_i = 1'h0;
	logic        die_over140_i = 1'h0, ext_temp_low_i = 1'h0;
	logic        over_current_i = 1'h0, over_voltage_i = 1'h0;
	logic        rect_over12_i = 1'h0, trim_sel_otp_i = 1'h0;
	logic        status_clr_i = 1'h0;
	logic [15:0] meas_power_mw_i = 16'h03E8;
	logic [11:0] power_gain_trim_i = 12'h6DB, power_offset_trim_i = 12'h6DB;
	logic [11:0] otp_gain_i = 12'hDB6, otp_offset_i = 12'h73F;
	logic [3:0]  cause_tab [5] = '{4'h8, 4'h4, 4'h4, 4'h2, 4'h1};
	logic        fault_int_n_o, fault_int_oe_o, overtemp_flag_o, rx_enable_o;
	logic        mod_sw_o, bit_valid, bit_val, line_idle;
	logic [3:0]  fault_cause_o;
	logic [15:0] received_power_report_o;
	int          bad_count = 0, compares = 0;
	always #10 clock_i = ~clock_i;
	wrx_top #(.RPP_PERIOD(2000), .HALF_BIT(4)) dut_u (.*);
	wrx_tx_model #(.HALF_BIT(4)) tx_u (.clock_i(clock_i),
		.sys_rst_i(sys_rst_i), .mod_sw_i(mod_sw_o), .bit_valid_o(bit_valid),
		.bit_o(bit_val), .idle_o(line_idle));
	task check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask
	task finish_test;
		if (bad_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	task get_bit(output logic b);
		int n;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (bit_valid !== 1'h1 && n < 3000);
		b = bit_val;
	endtask
	task get_byte(input logic s, output logic [7:0] d);
		logic [9:0] f;
		for (int i = 0; i < 10; i++)
			get_bit(f[i]);
		d = f[7:0];
		check({s, ^f[8:0], f[9]}, 16'h0003);
	endtask
	task get_pkt(input logic [7:0] eh, input logic [7:0] em);
		logic       b;
		logic [7:0] hdr, msg, chk;
		int         n;
		n = 0;
		while (line_idle !== 1'h1 && n < 3000) begin
			tick(1);
			n++;
		end
		n = 0;
		get_bit(b);
		while (b === 1'h1 && n < 20) begin
			n++;
			get_bit(b);
		end
		check(16'(n), 16'h000B);
		get_byte(b, hdr);
		get_bit(b);
		get_byte(b, msg);
		get_bit(b);
		get_byte(b, chk);
		check(hdr, eh);
		check(msg, em);
		check(chk, hdr ^ msg);
	endtask
	task pwr(input logic [11:0] g, input logic [11:0] o, input logic s,
		input logic [15:0] e);
		power_gain_trim_i <= g;
		power_offset_trim_i <= o;
		trim_sel_otp_i <= s;
		tick(64);
		check(received_power_report_o, e);
	endtask
	initial begin
		tick(20);
		sys_rst_i <= 1'h0;
		tick(4);
		check(fault_int_n_o, 16'h0000);
		check(fault_int_oe_o, 16'h0000);
		check(rx_enable_o, 16'h0001);
		for (int i = 0; i < 5; i++) begin
			{shdn_n_i, die_over140_i, ext_temp_low_i, over_voltage_i,
				over_current_i} <= 5'h10 >> i;
			tick(4);
			check(fault_int_oe_o, 16'h0001);
			check(fault_cause_o, cause_tab[i]);
			if (i != 2)
				check(rx_enable_o, i > 2);
			{shdn_n_i, die_over140_i, ext_temp_low_i, over_voltage_i,
				over_current_i} <= 5'h00;
			tick(4);
			status_clr_i <= 1'h1;
			tick(1);
			status_clr_i <= 1'h0;
			tick(4);
			check(fault_cause_o, 16'h0000);
		end
		pwr(12'h6DB, 12'h6DB, 1'h0, 16'h0546);
		pwr(12'hDB6, 12'h73F, 1'h0, 16'h0992);
		pwr(12'h6DB, 12'h6DB, 1'h1, 16'h0992);
		pwr(12'h000, 12'h000, 1'h0, 16'h0546);
		get_pkt(8'h04, 8'h05);
		rect_over12_i <= 1'h1;
		get_pkt(8'h03, 8'hF6);
		rect_over12_i <= 1'h0;
		charge_done_i <= 1'h1;
		get_pkt(8'h02, 8'h01);
		charge_done_i <= 1'h0;
		get_pkt(8'h02, 8'h01);
		uvlo_ok_i <= 1'h0;
		tick(8);
		check(rx_enable_o, 16'h0000);
		uvlo_ok_i <= 1'h1;
		get_pkt(8'h04, 8'h05);
		die_over130_i <= 1'h1;
		get_pkt(8'h02, 8'h03);
		check(overtemp_flag_o, 16'h0001);
		finish_test;
	end
	initial begin
		repeat (40000) @(posedge clock_i);
		bad_count++;
		finish_test;
	end
endmodule // tb_top
